/* File: brc_cfg.svh */
// Constants of the bridge reset and pin mode controller.
// Assumes a 20 MHz core clock; included by the design modules brc_rst_sync and brc_reset_ctrl.
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH

`define BRC_CLK_MHZ          20
`define BRC_CLK_STABLE_US    10
`define BRC_CLK_STABLE_CYC   ((`BRC_CLK_STABLE_US * `BRC_CLK_MHZ))
`define BRC_TRAIN_MAX_MS     80
`define BRC_TRAIN_MAX_CYC    ((`BRC_TRAIN_MAX_MS * 1000 * `BRC_CLK_MHZ))
`define BRC_TRAIN_DELAY_CYC  16
`define BRC_CLK_DET_EDGES    4
`define BRC_DIR_SIX_BIT      6
`define BRC_DIR_SEVEN_BIT    7
`define BRC_GPCTL_RST        8'h00

`endif

/* File: brc_pkg.sv */
// Types of the bridge reset and pin mode controller.
// Assumes brc_cfg.svh is on the include path.
package brc_pkg;

  typedef enum logic [2:0] {
    BRC_ST_POWER_WAIT,
    BRC_ST_CLOCK_WAIT,
    BRC_ST_CLOCK_SETTLE,
    BRC_ST_RUN
  } brc_por_state_t;

  typedef struct packed {
    logic por;
    logic perst;
    logic hot;
    logic sw_bus;
  } brc_reset_src_t;

  typedef struct packed {
    logic sticky_rst;
    logic core_rst;
    logic dl_rst;
    logic pci_bus_rst;
  } brc_reset_out_t;

endpackage

/* File: brc_rst_sync.sv */
// Reset synchroniser: asynchronous assertion, two-stage synchronous release.
// Assumes arst_n_i may fall at any time relative to clock_i.
`timescale 1ns/1ps
`include "brc_cfg.svh"
module brc_rst_sync
  import brc_pkg::*;
(
  // Clock and raw reset
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  // Synchronised reset
  output logic      srst_n_o
);

  logic stage1_q;
  logic stage2_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end

  assign srst_n_o = stage2_q;

endmodule

/* File: brc_reset_ctrl.sv */
// Reset sequencer and shared pin mode control of the bridge.
// Assumes supply sense and reference clock detect are synchronous to clock_i.
`timescale 1ns/1ps
`include "brc_cfg.svh"
module brc_reset_ctrl
  import brc_pkg::*;
#(
  parameter int unsigned CLK_STABLE_CYC = `BRC_CLK_STABLE_CYC,
  parameter int unsigned TRAIN_DELAY    = `BRC_TRAIN_DELAY_CYC
)(
  // Clock and resets
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       global_reset_n_i,
  input  wire logic       perst_n_i,
  // Power and clock monitors
  input  wire logic       core_supply_sense_i,
  input  wire logic       auxiliary_supply_i,
  input  wire logic       refclk_active_i,
  // Other reset sources
  input  wire logic       hot_reset_i,
  input  wire logic       sw_bus_reset_i,
  // General purpose control register value and pin data
  input  wire logic [7:0] gp_ctl_i,
  input  wire logic [2:0] gp_out_i,
  input  wire logic       sda_out_i,
  // Shared data pin and pins six, seven
  input  wire logic       gp_pin_five_i,
  output logic            gp_pin_five_o,
  output logic            gp_pin_five_oe_o,
  input  wire logic       gp_pin_six_i,
  output logic            gp_pin_six_o,
  output logic            gp_pin_six_oe_o,
  input  wire logic       gp_pin_seven_i,
  output logic            gp_pin_seven_o,
  output logic            gp_pin_seven_oe_o,
  // Status and reset outputs
  output logic            serial_mode_o,
  output logic [2:0]      gp_in_o,
  output brc_reset_out_t  resets_o,
  output logic            strap_latch_o,
  output logic            eeprom_start_o,
  output logic            train_start_o,
  output brc_reset_src_t  src_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Power-on reset sequencer

  logic           global_reset_n_sync_n;
  logic           perst_sync_n;
  brc_por_state_t st_q;
  brc_por_state_t st_d;
  logic [31:0]    cnt_q;
  logic [31:0]    cnt_d;
  logic           por_q;
  logic           por_d;

  // Global reset is a full power-on reset in normal and auxiliary power
  brc_rst_sync u_global_reset_n_sync (
    .clock_i  (clock_i),
    .arst_n_i (global_reset_n_i & rstn_i),
    .srst_n_o (global_reset_n_sync_n)
  );

  brc_rst_sync u_perst_sync (
    .clock_i  (clock_i),
    .arst_n_i (perst_n_i & global_reset_n_sync_n),
    .srst_n_o (perst_sync_n)
  );

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    por_d = por_q;
    case (st_q)
      BRC_ST_POWER_WAIT: begin
        por_d = 1'b1;
        if (core_supply_sense_i) begin
          st_d = BRC_ST_CLOCK_WAIT;
        end
      end
      BRC_ST_CLOCK_WAIT: begin
        cnt_d = 32'h0000_0000;
        if (!core_supply_sense_i) begin
          st_d = BRC_ST_POWER_WAIT;
        end else if (refclk_active_i) begin
          st_d = BRC_ST_CLOCK_SETTLE;
        end
      end
      BRC_ST_CLOCK_SETTLE: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (!core_supply_sense_i) begin
          st_d = BRC_ST_POWER_WAIT;
        end else if (!refclk_active_i) begin
          st_d = BRC_ST_CLOCK_WAIT;
        end else if (cnt_q == CLK_STABLE_CYC - 1) begin
          st_d  = BRC_ST_RUN;
          por_d = 1'b0;
        end
      end
      BRC_ST_RUN: begin
        por_d = 1'b0;
        if (!core_supply_sense_i) begin
          st_d  = BRC_ST_POWER_WAIT;
          por_d = 1'b1;
        end
      end
      default: begin
        st_d  = BRC_ST_POWER_WAIT;
        por_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge global_reset_n_sync_n) begin
    if (!global_reset_n_sync_n) begin
      st_q  <= BRC_ST_POWER_WAIT;
      cnt_q <= 32'h0000_0000;
      por_q <= 1'b1;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      por_q <= por_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset distribution

  logic full_rst;
  logic core_rst;
  assign full_rst = por_q | ~global_reset_n_sync_n;
  assign core_rst = full_rst | ~perst_sync_n;

  always_comb begin
    resets_o.sticky_rst  = full_rst;
    resets_o.core_rst    = core_rst;
    resets_o.dl_rst      = core_rst | hot_reset_i;
    resets_o.pci_bus_rst = core_rst | hot_reset_i | sw_bus_reset_i;
    src_o.por    = full_rst;
    src_o.perst  = ~perst_sync_n;
    src_o.hot    = hot_reset_i;
    src_o.sw_bus = sw_bus_reset_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Release actions: strap latch, EEPROM start, link training start

  logic       core_rst_q;
  logic       strap_q;
  logic       strap_d;
  logic       mode_q;
  logic       mode_d;
  logic       train_arm_q;
  logic       train_arm_d;
  logic [7:0] tcnt_q;
  logic [7:0] tcnt_d;
  logic       train_q;
  logic       train_d;
  logic       release_ev;

  assign release_ev = core_rst_q & ~core_rst;

  always_comb begin
    strap_d     = release_ev;
    mode_d      = mode_q;
    train_arm_d = train_arm_q;
    tcnt_d      = tcnt_q;
    train_d     = 1'b0;
    if (release_ev) begin
      mode_d      = gp_pin_five_i;
      train_arm_d = 1'b1;
      tcnt_d      = 8'h00;
    end else if (train_arm_q) begin
      tcnt_d = tcnt_q + 8'h01;
      if (tcnt_q == TRAIN_DELAY[7:0]) begin
        train_arm_d = 1'b0;
        train_d     = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      core_rst_q  <= 1'b1;
      strap_q     <= 1'b0;
      train_arm_q <= 1'b0;
      tcnt_q      <= 8'h00;
      train_q     <= 1'b0;
      mode_q      <= mode_q & ~full_rst;
    end else begin
      core_rst_q  <= 1'b0;
      strap_q     <= strap_d;
      train_arm_q <= train_arm_d;
      tcnt_q      <= tcnt_d;
      train_q     <= train_d;
      mode_q      <= mode_d;
    end
  end

  assign strap_latch_o  = strap_q;
  assign eeprom_start_o = strap_q & mode_q;
  assign train_start_o  = train_q;
  assign serial_mode_o  = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  logic [2:0] gp_in_q;
  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      gp_in_q <= 3'h0;
    end else begin
      gp_in_q <= {gp_pin_seven_i, gp_pin_six_i, gp_pin_five_i};
    end
  end
  assign gp_in_o = gp_in_q;

  // Serial data is open drain: it only ever pulls low
  assign gp_pin_five_o     = mode_q ? 1'b0 : gp_out_i[0];
  // Kept off in the strap sampling cycle so the pin is read undriven
  assign gp_pin_five_oe_o  = (core_rst | core_rst_q) ? 1'b0 :
                             (mode_q ? ~sda_out_i : gp_ctl_i[5]);
  assign gp_pin_six_o      = gp_out_i[1];
  assign gp_pin_six_oe_o   = ~core_rst & gp_ctl_i[`BRC_DIR_SIX_BIT];
  assign gp_pin_seven_o    = gp_out_i[2];
  assign gp_pin_seven_oe_o = ~core_rst & gp_ctl_i[`BRC_DIR_SEVEN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_POR_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !core_supply_sense_i |=> resets_o.sticky_rst)
    else $error("power-on reset released without supply");

  AST_POR_DELAY: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (st_q == BRC_ST_CLOCK_WAIT && refclk_active_i && core_supply_sense_i)
    |=> resets_o.sticky_rst)
    else $error("power-on reset released too early");

  AST_BUS_RST: assert property (@(posedge clock_i) disable iff (!rstn_i)
    resets_o.sticky_rst |-> resets_o.pci_bus_rst)
    else $error("bus reset not asserted with power-on reset");

  AST_GLOBAL_RESET_N: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !global_reset_n_i |=> st_q == BRC_ST_POWER_WAIT && por_q)
    else $error("global reset did not clear sequencer");

  AST_PERST: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !perst_n_i |=> resets_o.core_rst)
    else $error("perst did not reset core");

  AST_DIR: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !core_rst |-> gp_pin_six_oe_o == gp_ctl_i[6] && gp_pin_seven_oe_o == gp_ctl_i[7])
    else $error("pin direction mismatch");

  AST_MODE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    release_ev |=> mode_q == $past(gp_pin_five_i))
    else $error("pin five mode not latched");

  AST_GP_PIN_FIVE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (!mode_q && !core_rst && !core_rst_q) |-> gp_pin_five_oe_o == gp_ctl_i[5])
    else $error("pin five not in general purpose mode");

  AST_TRAIN: assert property (@(posedge clock_i) disable iff (!rstn_i)
    release_ev |-> ##[1:40] (train_q || core_rst))
    else $error("training not started");

  AST_SYNC: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(perst_n_i) && global_reset_n_sync_n |=> !perst_sync_n)
    else $error("perst release not delayed");

  AST_HOT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    hot_reset_i |-> resets_o.dl_rst && resets_o.pci_bus_rst)
    else $error("hot reset not applied");

endmodule

/* File: brc_sys_model.sv */
// Upstream system model: PERST, core supply and reference clock ordering.
// Assumes power_req_i is driven by the bench; all steps on clock_i edges.
`timescale 1ns/1ps
module brc_sys_model #(
  parameter int unsigned HOLD = 24,
  parameter int unsigned GAP  = 4
)(
  // Clock and command
  input  wire logic clock_i,
  input  wire logic power_req_i,
  // System outputs
  output logic      perst_n_o,
  output logic      supply_o,
  output logic      refclk_o
);
  ////////////////////////////////////////////////////////////////////////////
  // One process owns all three outputs
  initial begin
    perst_n_o = 1'b0;
    supply_o  = 1'b0;
    refclk_o  = 1'b0;
    forever begin
      do @(posedge clock_i); while (power_req_i !== 1'b1);
      perst_n_o <= 1'b0;
      repeat (GAP) @(posedge clock_i);
      supply_o <= 1'b1;
      repeat (GAP) @(posedge clock_i);
      refclk_o <= 1'b1;
      repeat (HOLD) @(posedge clock_i);
      perst_n_o <= 1'b1;
      do @(posedge clock_i); while (power_req_i !== 1'b0);
      perst_n_o <= 1'b0;
      repeat (GAP) @(posedge clock_i);
      refclk_o <= 1'b0;
      repeat (GAP) @(posedge clock_i);
      supply_o <= 1'b0;
    end
  end
endmodule

/* File: testbench.sv */
// Self-checking bench of the reset sequencer and pin mode control.
// Assumes brc_pkg is compiled first; system side comes from brc_sys_model.
`timescale 1ns/1ps
module testbench;
  import brc_pkg::*;
  localparam int unsigned CS = 4;
  localparam int unsigned TD = 16;
  logic clock_i, rstn_i, global_reset_n_n, pwr_req, aux, hot, sw, sda, pull5;
  logic [7:0] gp_ctl;
  logic [2:0] gp_out;
  logic perst_n, supply, refclk, p5, p5_oe, p6, p6_oe, p7, p7_oe;
  logic serial_mode, strap, eeprom, train;
  logic [2:0] gp_in;
  brc_reset_out_t rst;
  brc_reset_src_t src;
  int err_count, n_compared, n;
  wire pin5 = p5_oe ? p5 : pull5;
  wire pin6 = p6_oe ? p6 : 1'b1;
  wire pin7 = p7_oe ? p7 : 1'b1;
  brc_sys_model model (.clock_i(clock_i), .power_req_i(pwr_req), .perst_n_o(perst_n),
    .supply_o(supply), .refclk_o(refclk));
  brc_reset_ctrl #(.CLK_STABLE_CYC(CS), .TRAIN_DELAY(TD)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .global_reset_n_i(global_reset_n_n), .perst_n_i(perst_n),
    .core_supply_sense_i(supply), .auxiliary_supply_i(aux), .refclk_active_i(refclk),
    .hot_reset_i(hot), .sw_bus_reset_i(sw), .gp_ctl_i(gp_ctl), .gp_out_i(gp_out),
    .sda_out_i(sda), .gp_pin_five_i(pin5), .gp_pin_five_o(p5), .gp_pin_five_oe_o(p5_oe),
    .gp_pin_six_i(pin6), .gp_pin_six_o(p6), .gp_pin_six_oe_o(p6_oe),
    .gp_pin_seven_i(pin7), .gp_pin_seven_o(p7), .gp_pin_seven_oe_o(p7_oe),
    .serial_mode_o(serial_mode), .gp_in_o(gp_in), .resets_o(rst), .strap_latch_o(strap),
    .eeprom_start_o(eeprom), .train_start_o(train), .src_o(src));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up(input logic mode);
    pwr_req <= 1'b1;
    n = 0;
    while (refclk !== 1'b1 && n < 100) begin
      cyc(1);
      #1;
      n++;
    end
    cyc(2);
    #1 chk(src.por, 1'b1, "por released early");
    chk(rst.pci_bus_rst, 1'b1, "bus reset off during por");
    n = 2;
    while (src.por !== 1'b0 && n < 50) begin
      cyc(1);
      #1;
      n++;
    end
    chk(n == CS + 1, 1'b1, "por release time");
    n = 0;
    while (strap !== 1'b1 && n < 200) begin
      cyc(1);
      #1;
      n++;
    end
    chk(serial_mode, mode, "pin five mode");
    chk(eeprom, mode, "download start");
    n = 0;
    do begin cyc(1); n++; #1; end while (train !== 1'b1 && n < 100);
    chk(n == TD + 1, 1'b1, "training start time");
    cyc(1);
    #1 chk(train, 1'b0, "training pulse too long");
  endtask
  task automatic t_dir;
    cyc(1);
    gp_ctl <= 8'h40;
    gp_out <= 3'h2;
    cyc(1);
    #1 chk(p6_oe, 1'b1, "six not output");
    chk(p6, 1'b1, "six data");
    chk(p7_oe, 1'b0, "seven driven");
    cyc(1);
    gp_ctl <= 8'h80;
    gp_out <= 3'h4;
    cyc(1);
    #1 chk(p6_oe, 1'b0, "six driven");
    chk(p7_oe, 1'b1, "seven not output");
    chk(p7, 1'b1, "seven data");
    cyc(1);
    gp_ctl <= 8'hC0;
    gp_out <= 3'h0;
    sda <= 1'b0;
    cyc(2);
    #1 chk(p5_oe, 1'b1, "serial data not pulled");
    chk(p5, 1'b0, "serial data level");
    chk(gp_in == 3'h0, 1'b1, "pin inputs low");
    cyc(1);
    sda <= 1'b1;
    cyc(2);
    #1 chk(gp_in == 3'h1, 1'b1, "pin five not released");
  endtask
  task automatic t_hot_sw;
    cyc(1);
    hot <= 1'b1;
    cyc(3);
    #1 chk(src.hot, 1'b1, "hot source");
    chk(rst.dl_rst, 1'b1, "hot link reset");
    chk(rst.pci_bus_rst, 1'b1, "hot bus reset");
    chk(rst.sticky_rst, 1'b0, "hot clears sticky");
    cyc(1);
    hot <= 1'b0;
    sw <= 1'b1;
    cyc(3);
    #1 chk(src.sw_bus, 1'b1, "software source");
    chk(rst.pci_bus_rst, 1'b1, "software bus reset");
    chk(rst.dl_rst, 1'b0, "software hit link");
    cyc(1);
    sw <= 1'b0;
    cyc(2);
    #1 chk(rst.pci_bus_rst, 1'b0, "bus reset stuck");
  endtask
  task automatic t_power_down;
    cyc(1);
    pwr_req <= 1'b0;
    cyc(3);
    #1 chk(rst.core_rst, 1'b1, "perst core reset");
    chk(rst.sticky_rst, 1'b0, "perst hit sticky");
    chk(src.perst, 1'b1, "perst source");
    cyc(12);
    #1 chk(src.por, 1'b1, "por off without supply");
    cyc(1);
    pull5 <= 1'b1;
    gp_ctl <= 8'h00;
  endtask
  task automatic t_global;
    cyc(1);
    aux <= 1'b1;
    sda <= 1'b0;
    cyc(2);
    global_reset_n_n <= 1'b0;
    #1 chk(rst.sticky_rst, 1'b1, "global not asynchronous");
    chk(p5_oe, 1'b0, "pin five still driven");
    cyc(2);
    #1 chk(src.por, 1'b1, "global not power-on");
    chk(serial_mode, 1'b0, "mode kept");
    chk(rst.pci_bus_rst, 1'b1, "global bus reset");
    cyc(1);
    global_reset_n_n <= 1'b1;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    n_compared = 0;
    rstn_i = 1'b0;
    global_reset_n_n = 1'b1;
    pwr_req = 1'b0;
    aux = 1'b0;
    hot = 1'b0;
    sw = 1'b0;
    sda = 1'b1;
    pull5 = 1'b0;
    gp_ctl = 8'h20;
    gp_out = 3'h1;
    cyc(10);
    rstn_i <= 1'b1;
    cyc(2);
    t_power_up(1'b0);
    #1 chk(p5_oe, 1'b1, "pin five direction");
    chk(p5, 1'b1, "pin five data");
    t_hot_sw();
    t_power_down();
    t_power_up(1'b1);
    t_dir();
    t_global();
    complete_run();
  end
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
